/* File: hw/drd_defs.vh */
`ifndef DRD_DEFS_VH
`define DRD_DEFS_VH

// command codes
`define DRD_CMD_NATIVE_MAX   8'h27
`define DRD_CMD_READ         8'h20
`define DRD_CMD_READ_RETRY   8'h21
`define DRD_CMD_RETRY_BIT    0

// device register fields
`define DRD_DEV_LBA_BIT      6
`define DRD_DEV_HEAD_MSB     3

// error register bits
`define DRD_ERR_UNC_BIT      6
`define DRD_ERR_ABT_BIT      2

// status register bits
`define DRD_ST_BSY_BIT       7
`define DRD_ST_RDY_BIT       6
`define DRD_ST_DSC_BIT       4
`define DRD_ST_DRQ_BIT       3
`define DRD_ST_ERR_BIT       0

// counts and reset values
`define DRD_ZERO_COUNT_SECT  9'h100
`define DRD_WORDS_PER_SECT   256
`define DRD_NATIVE_MAX_DEF   48'h0000_0000_ffff
`define DRD_SECT_PER_TRACK   63
`define DRD_HEADS            16
`define DRD_BYTE_RESET       8'h00
`define DRD_WORD_RESET       16'h0000

`endif

/* File: hw/drd_addr_step.v */
`timescale 1ns/1ps
`include "drd_defs.vh"

module drd_addr_step #(
    parameter SECT_PER_TRACK = `DRD_SECT_PER_TRACK,
    parameter HEADS          = `DRD_HEADS
) (
    input  wire        lba_mode_i,
    input  wire [27:0] addr_i,
    output reg  [27:0] next_addr_o
);

    reg [7:0]  sect;
    reg [3:0]  head;
    reg [15:0] cyl;

    // packed as {head, cylinder, sector} or a flat lba
    always @* begin
        sect = addr_i[7:0];
        head = addr_i[27:24];
        cyl  = addr_i[23:8];
        if (lba_mode_i) begin
            next_addr_o = addr_i + 28'h0000001;
        end else begin
            if (sect >= SECT_PER_TRACK[7:0]) begin
                sect = 8'h01;
                if ({1'b0, head} >= HEADS[4:0] - 5'h01) begin
                    head = 4'h0;
                    cyl  = cyl + 16'h0001;
                end else begin
                    head = head + 4'h1;
                end
            end else begin
                sect = sect + 8'h01;
            end
            next_addr_o = {head, cyl, sect};
        end
    end

endmodule // drd_addr_step

/* File: hw/drd_cmd_decoder.v */
// Operation
// R1: command 27h is decoded as the native maximum address query.
// R2: the query reports the true native maximum, never a reduced one.
// R3: 48-bit result split over low/mid/high, byte select picks upper half.
// R4: codes 20h and 21h both start the same sector read.
// R5: each sector is fetched from media before its data goes out.
// R6: sector data leaves through the data port sixteen bits per transfer.
// R7: an uncorrectable error stops the read at the failing sector.
// R8: the sector count gives the sectors to read; zero means 256.
// R9: chs mode takes sector, cylinder and head from the address registers.
// R10: lba mode builds a 28-bit start address from the four registers.
// R11: the retry bit of the read command code is ignored.
// R12: at completion sector count holds sectors not transferred.
// R13: at completion address registers hold the last transferred sector; after an uncorrectable error the code loads the failing sector there instead.
// R14: host sets lba mode before the query and reads after busy clears.
// R15: host reads the upper bytes by setting byte select and reading again.
`timescale 1ns/1ps
`include "drd_defs.vh"

module drd_cmd_decoder #(
    parameter [47:0] NATIVE_MAX     = `DRD_NATIVE_MAX_DEF,
    parameter        WORDS_PER_SECT = `DRD_WORDS_PER_SECT,
    parameter        SECT_PER_TRACK = `DRD_SECT_PER_TRACK,
    parameter        HEADS          = `DRD_HEADS
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cmd_wr_i,
    input  wire [7:0]  cmd_code_i,
    input  wire [7:0]  sect_count_i,
    input  wire [7:0]  lba_low_i,
    input  wire [7:0]  lba_mid_i,
    input  wire [7:0]  lba_high_i,
    input  wire [7:0]  device_i,
    input  wire        high_order_byte_select_i,
    input  wire        data_rd_i,
    input  wire        media_done_i,
    input  wire        media_unc_i,
    input  wire        media_word_valid_i,
    input  wire [15:0] media_word_i,
    output reg  [7:0]  status_o,
    output reg  [7:0]  error_o,
    output reg  [7:0]  sect_count_o,
    output reg  [7:0]  lba_low_o,
    output reg  [7:0]  lba_mid_o,
    output reg  [7:0]  lba_high_o,
    output reg  [7:0]  device_o,
    output reg  [15:0] data_o,
    output reg         media_req_o,
    output reg  [27:0] media_addr_o,
    output reg         media_lba_mode_o,
    output reg         media_word_req_o
);

    localparam [5:0] ST_IDLE  = 6'b000001;
    localparam [5:0] ST_FETCH = 6'b000010;
    localparam [5:0] ST_REQ   = 6'b000100;
    localparam [5:0] ST_WAIT  = 6'b001000;
    localparam [5:0] ST_HOST  = 6'b010000;
    localparam [5:0] ST_QUERY = 6'b100000;

    localparam integer WORDS_LAST = WORDS_PER_SECT - 1;
    localparam [8:0]   WORDS_M1   = WORDS_LAST[8:0];
    localparam [7:0]   CMD_QUERY  = `DRD_CMD_NATIVE_MAX;
    localparam [7:0]   CMD_READ   = `DRD_CMD_READ;
    localparam [7:0]   CMD_RETRY  = `DRD_CMD_READ_RETRY;

    reg [5:0]  state;
    reg [5:0]  next_state;
    reg [8:0]  remain;
    reg [8:0]  word_cnt;
    reg [27:0] cur_addr;
    reg        lba_mode;
    reg [47:0] res_addr;
    reg [8:0]  res_count;
    reg        busy;
    reg        drq;
    reg        err;
    reg        unc;
    reg        abt;
    reg        high_order_byte_select;
    wire [27:0] step_addr;
    wire [23:0] shown_addr;

    // query decode, shared by next state and command capture
    function is_query;
        input [7:0] code;
        begin
            is_query = (code == CMD_QUERY); // see R1
        end
    endfunction

    // read codes differ only in the retry bit, which changes nothing
    function is_read;
        input [7:0] code;
        begin
            is_read = (code == CMD_READ) || (code == CMD_RETRY); // see R4 see R11
        end
    endfunction

    function [7:0] pack_status;
        input bsy_f;
        input drq_f;
        input err_f;
        begin
            pack_status                  = 8'h00;
            pack_status[`DRD_ST_BSY_BIT] = bsy_f;
            pack_status[`DRD_ST_RDY_BIT] = 1'b1;
            pack_status[`DRD_ST_DSC_BIT] = 1'b1;
            pack_status[`DRD_ST_DRQ_BIT] = drq_f;
            pack_status[`DRD_ST_ERR_BIT] = err_f;
        end
    endfunction

    function [7:0] pack_error;
        input unc_f;
        input abt_f;
        begin
            pack_error                   = 8'h00;
            pack_error[`DRD_ERR_UNC_BIT] = unc_f;
            pack_error[`DRD_ERR_ABT_BIT] = abt_f;
        end
    endfunction

    drd_addr_step #(
        .SECT_PER_TRACK (SECT_PER_TRACK),
        .HEADS          (HEADS)
    ) u_step (
        .lba_mode_i  (lba_mode),
        .addr_i      (cur_addr),
        .next_addr_o (step_addr)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cmd_wr_i) begin
                    if (is_query(cmd_code_i)) begin // see R1
                        next_state = ST_QUERY;
                    end else if (is_read(cmd_code_i)) begin // see R4
                        next_state = ST_FETCH;
                    end
                end
            end
            ST_QUERY: begin
                next_state = ST_IDLE;
            end
            ST_FETCH: begin
                if (media_done_i) begin
                    next_state = media_unc_i ? ST_IDLE : ST_REQ; // see R5 see R7
                end
            end
            ST_REQ: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (media_word_valid_i) begin
                    next_state = ST_HOST;
                end
            end
            ST_HOST: begin
                if (data_rd_i) begin
                    if (word_cnt != WORDS_M1) begin
                        next_state = ST_REQ;
                    end else if (remain == 9'h001) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_FETCH;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state            <= ST_IDLE;
            remain           <= 9'h000;
            word_cnt         <= 9'h000;
            cur_addr         <= 28'h0000000;
            lba_mode         <= 1'b0;
            res_addr         <= 48'h000000000000;
            res_count        <= 9'h000;
            busy             <= 1'b0;
            drq              <= 1'b0;
            err              <= 1'b0;
            unc              <= 1'b0;
            abt              <= 1'b0;
            media_req_o      <= 1'b0;
            media_addr_o     <= 28'h0000000;
            media_lba_mode_o <= 1'b0;
            media_word_req_o <= 1'b0;
            data_o           <= `DRD_WORD_RESET;
        end else begin
            state            <= next_state;
            media_word_req_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cmd_wr_i) begin
                        err <= 1'b0;
                        unc <= 1'b0;
                        abt <= 1'b0;
                        if (is_query(cmd_code_i)) begin
                            busy <= 1'b1;
                        end else if (is_read(cmd_code_i)) begin
                            busy     <= 1'b1;
                            lba_mode <= device_i[`DRD_DEV_LBA_BIT];
                            // chs and lba share one packing: see R9 see R10
                            cur_addr <= {device_i[`DRD_DEV_HEAD_MSB:0], lba_high_i,
                                         lba_mid_i, lba_low_i};
                            media_addr_o <= {device_i[`DRD_DEV_HEAD_MSB:0], lba_high_i,
                                             lba_mid_i, lba_low_i};
                            media_lba_mode_o <= device_i[`DRD_DEV_LBA_BIT];
                            media_req_o <= 1'b1; // see R5
                            remain <= (sect_count_i == 8'h00) ?
                                      `DRD_ZERO_COUNT_SECT : {1'b0, sect_count_i}; // see R8
                        end else begin
                            abt <= 1'b1;
                            err <= 1'b1;
                        end
                    end
                end
                ST_QUERY: begin
                    res_addr  <= NATIVE_MAX; // see R2 see R3
                    res_count <= 9'h000;
                    busy      <= 1'b0;
                end
                ST_FETCH: begin
                    word_cnt <= 9'h000;
                    if (media_done_i) begin
                        media_req_o <= 1'b0;
                        if (media_unc_i) begin
                            busy      <= 1'b0; // see R7
                            err       <= 1'b1;
                            unc       <= 1'b1;
                            res_count <= remain; // see R12
                            res_addr  <= {20'h00000, cur_addr};
                        end else begin
                            media_word_req_o <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    if (media_word_valid_i) begin
                        data_o <= media_word_i; // see R6
                        drq    <= 1'b1;
                    end
                end
                ST_HOST: begin
                    if (data_rd_i) begin
                        drq      <= 1'b0;
                        word_cnt <= word_cnt + 9'h001;
                        if (word_cnt != WORDS_M1) begin
                            media_word_req_o <= 1'b1;
                        end else begin
                            remain    <= remain - 9'h001;
                            res_addr  <= {20'h00000, cur_addr}; // see R13
                            res_count <= remain - 9'h001; // see R12
                            cur_addr  <= step_addr;
                            if (remain == 9'h001) begin
                                busy <= 1'b0;
                            end else begin
                                media_addr_o <= step_addr;
                                media_req_o  <= 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    drq <= drq;
                end
            endcase
        end
    end

    // byte select mux over the three address registers: see R3
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_hob
            assign shown_addr[gi*8 +: 8] = high_order_byte_select ? res_addr[24 + gi*8 +: 8]
                                               : res_addr[gi*8 +: 8];
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            high_order_byte_select          <= 1'b0;
            status_o     <= `DRD_BYTE_RESET;
            error_o      <= `DRD_BYTE_RESET;
            sect_count_o <= `DRD_BYTE_RESET;
            lba_low_o    <= `DRD_BYTE_RESET;
            lba_mid_o    <= `DRD_BYTE_RESET;
            lba_high_o   <= `DRD_BYTE_RESET;
            device_o     <= `DRD_BYTE_RESET;
        end else begin
            high_order_byte_select          <= high_order_byte_select_i;
            status_o     <= pack_status(busy, drq, err);
            error_o      <= pack_error(unc, abt);
            sect_count_o <= high_order_byte_select ? 8'h00 : res_count[7:0];
            lba_low_o    <= shown_addr[7:0];
            lba_mid_o    <= shown_addr[15:8];
            lba_high_o   <= shown_addr[23:16];
            device_o     <= {4'h0, res_addr[27:24]}; // see R13
        end
    end

endmodule // drd_cmd_decoder

/* File: dv/drd_media_model.sv */
`timescale 1ns/1ps
module drd_media_model (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        req_i,
    input  wire        word_req_i,
    input  wire [27:0] addr_i,
    input  wire [3:0]  lat_i,
    input  wire [8:0]  fail_at_i,
    output reg         done_o,
    output reg         unc_o,
    output reg         valid_o,
    output reg  [15:0] word_o
);
    reg [3:0] wait_n;
    reg [7:0] sect;
    reg [7:0] idx;
    always @(posedge clk_i) begin
        done_o  <= 1'b0;
        unc_o   <= 1'b0;
        valid_o <= 1'b0;
        word_o  <= ~word_o; // idle bus never holds the last word
        if (rst_i) begin
            wait_n <= 4'h0;
            idx    <= 8'h00;
            sect   <= 8'h00;
            word_o <= 16'h0000;
        end else begin
            if (req_i && !done_o) begin
                wait_n <= wait_n + 4'h1;
                if (wait_n == lat_i) begin
                    done_o <= 1'b1;
                    unc_o  <= fail_at_i == {1'b0, addr_i[7:0]};
                    wait_n <= 4'h0;
                    sect   <= addr_i[7:0];
                    idx    <= 8'h00;
                end
            end
            if (word_req_i) begin
                valid_o <= 1'b1;
                word_o  <= {sect, idx};
                idx     <= idx + 8'h01;
            end
        end
    end
endmodule // drd_media_model

/* File: dv/drd_cmd_decoder_props.sv */
`timescale 1ns/1ps
module drd_cmd_decoder_props #(
    parameter [47:0] NATIVE_MAX = 48'h0
) (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cmd_wr_i,
    input wire [7:0]  cmd_code_i,
    input wire        high_order_byte_select_i,
    input wire        media_done_i,
    input wire        media_unc_i,
    input wire        media_word_valid_i,
    input wire [15:0] media_word_i,
    input wire [7:0]  status_o,
    input wire [7:0]  error_o,
    input wire [7:0]  lba_low_o,
    input wire [7:0]  lba_mid_o,
    input wire [7:0]  lba_high_o,
    input wire [15:0] data_o,
    input wire        media_req_o,
    input wire        media_word_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cmd_wr_i && !status_o[7] && !$past(cmd_wr_i);
    endsequence
    a_read_start:
        assert property (s_take ##0 (cmd_code_i == 8'h20 || cmd_code_i == 8'h21) |=> media_req_o)
        else $error("read command started no fetch");
    a_query_low:
        assert property (s_take ##0 (cmd_code_i == 8'h27 && !high_order_byte_select_i)
            ##1 !high_order_byte_select_i [*2]
            |=> {lba_high_o, lba_mid_o, lba_low_o} == NATIVE_MAX[23:0])
        else $error("query result bytes wrong");
    a_unknown_abort:
        assert property (s_take ##0 !(cmd_code_i inside {8'h20, 8'h21, 8'h27})
            |-> ##[1:3] (status_o[0] && error_o[2]))
        else $error("unknown code not aborted");
    a_fetch_hold:
        assert property (media_req_o && !media_done_i |=> media_req_o)
        else $error("fetch request dropped early");
    a_word_after_fetch:
        assert property (media_req_o && media_done_i && !media_unc_i
            |=> media_word_req_o && !media_req_o)
        else $error("no word request after fetch");
    a_unc_no_word:
        assert property (media_req_o && media_done_i && media_unc_i |=> !media_word_req_o [*4])
        else $error("words requested after bad sector");
    a_unc_flag:
        assert property (media_req_o && media_done_i && media_unc_i
            |-> ##[1:3] (error_o[6] && status_o[0] && !status_o[7]))
        else $error("bad sector not flagged");
    a_data_capture:
        assert property (media_word_valid_i |=> data_o == $past(media_word_i))
        else $error("data word not passed on");
    a_word_pulse:
        assert property (media_word_req_o |=> !media_word_req_o)
        else $error("word request longer than one cycle");
    c_query: cover property (s_take ##0 cmd_code_i == 8'h27);
    c_read: cover property (media_done_i && !media_unc_i);
    c_unc: cover property (media_done_i && media_unc_i);
endmodule // drd_cmd_decoder_props
bind drd_cmd_decoder drd_cmd_decoder_props #(.NATIVE_MAX(NATIVE_MAX)) u_props (.clk_i, .rst_i,
    .cmd_wr_i, .cmd_code_i, .high_order_byte_select_i, .media_done_i, .media_unc_i,
    .media_word_valid_i, .media_word_i, .status_o, .error_o, .lba_low_o, .lba_mid_o,
    .lba_high_o, .data_o, .media_req_o, .media_word_req_o);

/* File: dv/test_drd_cmd_decoder.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module test_drd_cmd_decoder;
    localparam W = 4;
    localparam [47:0] NM = 48'h1234_5678_9abc;
    logic clk_i = 0, rst_i = 1, cmd_wr_i = 0, high_order_byte_select_i = 0, data_rd_i = 0;
    logic [7:0] cmd_code_i = 0, sect_count_i = 0, lba_low_i = 0, lba_mid_i = 0;
    logic [7:0] lba_high_i = 0, device_i = 0;
    logic [3:0] lat = 0;
    logic [8:0] fail_at = 9'h100;
    wire media_done_i, media_unc_i, media_word_valid_i, media_req_o, media_lba_mode_o;
    wire media_word_req_o;
    wire [15:0] media_word_i, data_o;
    wire [7:0] status_o, error_o, sect_count_o, lba_low_o, lba_mid_o, lba_high_o, device_o;
    wire [27:0] media_addr_o;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    drd_cmd_decoder #(.NATIVE_MAX(NM), .WORDS_PER_SECT(W)) dut (.clk_i, .rst_i, .cmd_wr_i,
        .cmd_code_i, .sect_count_i, .lba_low_i, .lba_mid_i, .lba_high_i, .device_i,
        .high_order_byte_select_i, .data_rd_i, .media_done_i, .media_unc_i,
        .media_word_valid_i, .media_word_i, .status_o, .error_o, .sect_count_o, .lba_low_o,
        .lba_mid_o, .lba_high_o, .device_o, .data_o, .media_req_o, .media_addr_o,
        .media_lba_mode_o, .media_word_req_o);
    drd_media_model mdl (.clk_i, .rst_i, .req_i(media_req_o), .word_req_i(media_word_req_o),
        .addr_i(media_addr_o), .lat_i(lat), .fail_at_i(fail_at), .done_o(media_done_i),
        .unc_o(media_unc_i), .valid_o(media_word_valid_i), .word_o(media_word_i));
    always #4 clk_i = ~clk_i;
    task tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    task automatic issue(input [7:0] c, n, lo, mi, hi, dv);
        @(negedge clk_i);
        {cmd_code_i, sect_count_i, lba_low_i, lba_mid_i, lba_high_i, device_i} =
            {c, n, lo, mi, hi, dv};
        cmd_wr_i = 1;
        @(negedge clk_i);
        cmd_wr_i = 0;
    endtask
    task automatic host_read(input [7:0] lo0, input int nw, input int wrap = 0);
        int k, n;
        k = 0;
        n = 0;
        repeat (3) @(negedge clk_i);
        while (status_o[7] === 1'b1 && n < 20000) begin
            if (data_rd_i) data_rd_i = 0;
            else if (status_o[3] === 1'b1) begin
                `CHK("data", {8'(lo0 + k / W - (k >= W ? wrap : 0)), 8'(k % W)}, data_o)
                k++;
                data_rd_i = 1;
            end
            @(negedge clk_i);
            n++;
        end
        data_rd_i = 0;
        `CHK("words", nw, k)
    endtask
    task t_query;
        issue(8'h27, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40);
        host_read(8'h00, 0);
        `CHK("max low", NM[23:0], {lba_high_o, lba_mid_o, lba_low_o})
        high_order_byte_select_i = 1;
        repeat (3) @(negedge clk_i);
        `CHK("max high", NM[47:24], {lba_high_o, lba_mid_o, lba_low_o})
        high_order_byte_select_i = 0;
        repeat (3) @(negedge clk_i);
    endtask
    task t_read_lba;
        for (int i = 0; i < 2; i++) begin
            lat = i ? 4'h9 : 4'h0;
            issue(i ? 8'h21 : 8'h20, 8'h02, 8'h10, 8'h67, 8'h45, 8'h43);
            @(negedge clk_i);
            `CHK("fetch addr", {1'b1, 28'h3456710}, {media_lba_mode_o, media_addr_o})
            host_read(8'h10, 2 * W);
            `CHK("left", 8'h00, sect_count_o)
            `CHK("last", 28'h4567113, {lba_high_o, lba_mid_o, lba_low_o, device_o[3:0]})
        end
    endtask
    task t_read_chs;
        // last sector of the last head: next sector wraps to sector 1, head 0, next cylinder
        issue(8'h20, 8'h02, 8'h3f, 8'h34, 8'h12, 8'h0f);
        @(negedge clk_i);
        `CHK("chs mode", 1'b0, media_lba_mode_o)
        host_read(8'h3f, 2 * W, 63);
        `CHK("chs last", 28'h1235010, {lba_high_o, lba_mid_o, lba_low_o, device_o[3:0]})
    endtask
    task t_zero_count;
        lat = 4'h1;
        issue(8'h20, 8'h00, 8'h00, 8'h01, 8'h00, 8'h40);
        host_read(8'h00, 256 * W);
        `CHK("zero left", 8'h00, sect_count_o)
        `CHK("zero last", 16'h01ff, {lba_mid_o, lba_low_o})
    endtask
    task t_unc;
        fail_at = 9'h022;
        issue(8'h21, 8'h05, 8'h20, 8'h00, 8'h00, 8'h40);
        host_read(8'h20, 2 * W);
        `CHK("unc left", 8'h03, sect_count_o)
        `CHK("unc addr", 8'h22, lba_low_o)
        `CHK("unc flags", 2'b11, {error_o[6], status_o[0]})
        fail_at = 9'h100;
    endtask
    task t_abort;
        issue(8'h30, 8'h01, 8'h00, 8'h00, 8'h00, 8'h40);
        repeat (4) @(negedge clk_i);
        `CHK("abort", 3'b011, {status_o[7], status_o[0], error_o[2]})
    endtask
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 0;
        repeat (2) @(negedge clk_i);
        `CHK("idle status", 8'h50, status_o)
        t_query;
        t_read_lba;
        t_read_chs;
        t_zero_count;
        t_unc;
        t_abort;
        tally_and_finish;
    end
endmodule // test_drd_cmd_decoder
